/* hw/acs_prescaler.v */
// Converter clock tick generator with enforced minimum period
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_prescaler #(
   parameter DIV_W = 8
) (
   // Clock and reset
   input  wire             sys_clk_in,
   input  wire             rst_in,
   input  wire             ce_in,
   // Control
   input  wire             run_in,
   input  wire [DIV_W-1:0] div_in,
   // Tick
   output reg              tick_out
);
   // Cycles needed so one tick period covers the minimum, rounded up
   localparam integer MIN_CYC =
      (`ACS_TC_AD_MIN_PS + `ACS_CLK_PERIOD_PS - 1) / `ACS_CLK_PERIOD_PS;
   localparam [DIV_W-1:0] MIN_DIV = MIN_CYC[DIV_W-1:0];
   reg  [DIV_W-1:0] cnt;
   wire [DIV_W-1:0] eff_div;
   // Software divider clamped so the period never goes short
   assign eff_div = (div_in < MIN_DIV) ? MIN_DIV : div_in; // RULE1
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         cnt      <= {DIV_W{1'b0}};
         tick_out <= 1'b0;
      end else if (ce_in) begin
         tick_out <= 1'b0;
         if (!run_in) begin
            cnt <= {DIV_W{1'b0}};
         end else if (cnt >= eff_div - 1'b1) begin
            cnt      <= {DIV_W{1'b0}};
            tick_out <= 1'b1; // RULE1
         end else begin
            cnt <= cnt + 1'b1;
         end
      end
   end
endmodule // acs_prescaler

/* hw/acs_sequencer.v */
// Conversion sequencer: start delay, sample, convert, load, interrupt
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_sequencer #(
   parameter DIV_W = 8,
   parameter RES_W = 10
) (
   // Clock and reset
   input  wire             sys_clk_in,
   input  wire             rst_in,
   input  wire             ce_in,
   // Trigger and control
   input  wire             soc_in,
   input  wire [4:0]       acquisition_window_prescale_in,
   input  wire [DIV_W-1:0] conv_clk_div_in,
   input  wire             flag_clear_in,
   // Analog stage
   input  wire [RES_W-1:0] conv_data_in,
   output reg              sample_out,
   output reg              convert_out,
   // Results and status
   output reg  [RES_W-1:0] result_out,
   output reg              done_flag_out,
   output reg              irq_out,
   output reg              busy_out
);
   // Whole operation minimum in system cycles, rounded up
   localparam integer TOTAL_MIN_CYC =
      (`ACS_TOTAL_MIN_NS * 1000 + `ACS_CLK_PERIOD_PS - 1) /
      `ACS_CLK_PERIOD_PS;
   localparam [7:0] TOTAL_MIN = TOTAL_MIN_CYC[7:0];
   localparam [5:0] SH_MIN = `ACS_SH_MIN_TICKS;
   localparam [5:0] SH_MAX = `ACS_SH_MAX_TICKS;
   localparam [5:0] CONV_T = `ACS_CONV_TICKS;
   localparam [1:0] SOC_D = `ACS_SOC_DELAY_CYC;
   localparam [1:0] EOC_D = `ACS_EOC_DELAY_CYC;
   localparam [1:0] INT_D = `ACS_INT_DELAY_CYC;

   reg  [2:0] state;
   reg  [5:0] ticks;
   reg  [5:0] sh_len;
   reg  [1:0] dly;
   reg  [7:0] total;
   reg  [1:0] irq_dly;
   reg        irq_pend;
   wire       tick;
   wire [5:0] req_len;

   // Prescale setting n selects n+1 ticks, kept within 2..32
   assign req_len = {1'b0, acquisition_window_prescale_in} + 6'h01;

   acs_prescaler #(
      .DIV_W (DIV_W)
   ) u_presc (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .ce_in      (ce_in),
      .run_in     (sample_out | convert_out),
      .div_in     (conv_clk_div_in),
      .tick_out   (tick)
   );

   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         state         <= `ACS_ST_IDLE;
         ticks         <= 6'h00;
         sh_len        <= SH_MIN;
         dly           <= 2'h0;
         total         <= 8'h00;
         irq_dly       <= 2'h0;
         irq_pend      <= 1'b0;
         sample_out    <= 1'b0;
         convert_out   <= 1'b0;
         result_out    <= {RES_W{1'b0}};
         done_flag_out <= 1'b0;
         irq_out       <= 1'b0;
         busy_out      <= 1'b0;
      end else if (ce_in) begin
         if (state != `ACS_ST_IDLE && total != 8'hff)
            total <= total + 8'h01;
         case (state)
            `ACS_ST_IDLE: begin
               if (soc_in) begin
                  state    <= `ACS_ST_SOC;
                  dly      <= 2'h1;
                  total    <= 8'h01;
                  busy_out <= 1'b1;
                  if (req_len < SH_MIN)
                     sh_len <= SH_MIN; // RULE4
                  else if (req_len > SH_MAX)
                     sh_len <= SH_MAX;
                  else
                     sh_len <= req_len; // RULE4
               end
            end
            `ACS_ST_SOC: begin
               if (dly >= SOC_D) begin // RULE3
                  state      <= `ACS_ST_SAMPLE;
                  sample_out <= 1'b1;
                  ticks      <= 6'h00;
               end else begin
                  dly <= dly + 2'h1;
               end
            end
            `ACS_ST_SAMPLE: begin
               if (tick) begin
                  if (ticks + 6'h01 >= sh_len) begin // RULE4
                     state       <= `ACS_ST_CONV;
                     sample_out  <= 1'b0;
                     convert_out <= 1'b1;
                     ticks       <= 6'h00;
                  end else begin
                     ticks <= ticks + 6'h01;
                  end
               end
            end
            `ACS_ST_CONV: begin
               if (tick) begin
                  if (ticks + 6'h01 >= CONV_T) begin // RULE5
                     state       <= `ACS_ST_EOC;
                     convert_out <= 1'b0;
                     dly         <= 2'h1;
                  end else begin
                     ticks <= ticks + 6'h01;
                  end
               end
            end
            `ACS_ST_EOC: begin
               // Stretch the load so the whole operation meets its floor
               if (dly >= EOC_D && total >= TOTAL_MIN) begin // RULE6 RULE2
                  state         <= `ACS_ST_IDLE;
                  busy_out      <= 1'b0;
                  result_out    <= conv_data_in;
                  done_flag_out <= 1'b1; // RULE8
                  irq_pend      <= 1'b1;
                  irq_dly       <= 2'h1;
               end else if (dly < EOC_D) begin
                  dly <= dly + 2'h1;
               end
            end
            default: state <= `ACS_ST_IDLE;
         endcase
         // Clear loses to a simultaneous set
         if (flag_clear_in && !(state == `ACS_ST_EOC && dly >= EOC_D &&
             total >= TOTAL_MIN))
            done_flag_out <= 1'b0; // RULE8
         // Interrupt follows flag by the delay, one pulse
         irq_out <= 1'b0;
         if (irq_pend && !(state == `ACS_ST_EOC && dly >= EOC_D &&
             total >= TOTAL_MIN)) begin
            if (irq_dly >= INT_D) begin // RULE7
               irq_out  <= 1'b1;
               irq_pend <= 1'b0;
            end else begin
               irq_dly <= irq_dly + 2'h1;
            end
         end
      end
   end
endmodule // acs_sequencer

/* include/acs_regs.vh */
// Timing constants for the converter conversion sequencer
// Behaviour
// RULE1 - Converter clock period never below 33.3 ns
// RULE2 - Whole operation lasts at least 500 ns
// RULE3 - Wait two CPU clocks before sampling
// RULE4 - Sample window 2 to 32 converter clocks
// RULE5 - Conversion takes at least ten converter clocks
// RULE6 - Result loaded two CPU clocks after conversion
// RULE7 - Interrupt raised two CPU clocks after flag
// RULE8 - Flag sets with result load, software clears
`ifndef ACS_REGS_VH
`define ACS_REGS_VH
`define ACS_CLK_PERIOD_PS      5000
`define ACS_TC_AD_MIN_PS       33300
`define ACS_TOTAL_MIN_NS       500
`define ACS_SOC_DELAY_CYC      2
`define ACS_EOC_DELAY_CYC      2
`define ACS_INT_DELAY_CYC      2
`define ACS_CONV_TICKS         10
`define ACS_SH_MIN_TICKS       2
`define ACS_SH_MAX_TICKS       32
`define ACS_ST_IDLE            3'h0
`define ACS_ST_SOC             3'h1
`define ACS_ST_SAMPLE          3'h2
`define ACS_ST_CONV            3'h3
`define ACS_ST_EOC             3'h4
`endif

/* tb/acs_analog_model.sv */
// Behavioural analog sampling stage feeding the sequencer
`timescale 1ns/1ps
module acs_analog_model (
   // Clock and phases
   input  wire       sys_clk_in,
   input  wire       sample_in,
   input  wire       convert_in,
   input  wire       busy_in,
   // Value
   input  wire [9:0] value_in,
   output wire [9:0] data_out
);
   reg [9:0] held = 10'h000;
   always @(posedge sys_clk_in) begin
      if (sample_in) begin
         held <= value_in;
      end
   end
   // Outside the load gap the bus shows junk, so a stale read is caught
   assign data_out = (busy_in && !sample_in && !convert_in) ? held : ~held;
endmodule // acs_analog_model

/* tb/acs_seq_monitor.sv */
// Timing checker bound to the conversion sequencer
`timescale 1ns/1ps
module acs_seq_monitor #(
   parameter RES_W = 10
) (
   // Clock, reset and inputs
   input wire             sys_clk_in,
   input wire             rst_in,
   input wire             flag_clear_in,
   input wire [RES_W-1:0] conv_data_in,
   // Outputs
   input wire             sample_out,
   input wire             convert_out,
   input wire [RES_W-1:0] result_out,
   input wire             done_flag_out,
   input wire             irq_out,
   input wire             busy_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   reg [13:0] sh_n, cv_n, bz_n;
   // Phase lengths in sys clocks, zeroed while the phase is low
   always @(posedge sys_clk_in) begin
      sh_n <= (rst_in || !sample_out) ? 14'h0000 : sh_n + 14'h0001;
      cv_n <= (rst_in || !convert_out) ? 14'h0000 : cv_n + 14'h0001;
      bz_n <= (rst_in || !busy_out) ? 14'h0000 : bz_n + 14'h0001;
   end
   property p_soc;
      $rose(sample_out) |-> $past(busy_out, 2) && !$past(busy_out, 3);
   endproperty
   a_soc: assert property (p_soc) else $error("sample too early");
   property p_win;
      $fell(sample_out) |-> convert_out && sh_n >= 14'h000E;
   endproperty
   a_win: assert property (p_win) else $error("window short");
   property p_cnv;
      $fell(convert_out) |-> cv_n >= 14'h0046;
   endproperty
   a_cnv: assert property (p_cnv) else $error("conversion short");
   property p_tot;
      $fell(busy_out) |-> bz_n >= 14'h0063;
   endproperty
   a_tot: assert property (p_tot) else $error("operation short");
   property p_eoc;
      $rose(done_flag_out) |-> !$past(convert_out) && !$past(convert_out, 2);
   endproperty
   a_eoc: assert property (p_eoc) else $error("load too early");
   property p_irq;
      $rose(done_flag_out) |-> !irq_out ##1 !irq_out ##1 irq_out ##1 !irq_out;
   endproperty
   a_irq: assert property (p_irq) else $error("irq timing");
   property p_ld;
      $rose(done_flag_out) |->
         $fell(busy_out) && result_out == $past(conv_data_in);
   endproperty
   a_ld: assert property (p_ld) else $error("load mismatch");
   property p_hold;
      done_flag_out && !flag_clear_in |=> done_flag_out;
   endproperty
   a_hold: assert property (p_hold) else $error("flag lost");
endmodule // acs_seq_monitor
bind acs_sequencer acs_seq_monitor #(.RES_W(RES_W)) i_mon (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .flag_clear_in(flag_clear_in),
   .conv_data_in(conv_data_in), .sample_out(sample_out),
   .convert_out(convert_out), .result_out(result_out),
   .done_flag_out(done_flag_out), .irq_out(irq_out), .busy_out(busy_out));

/* tb/test_adc_conversion_sequencer_timing.sv */
// Testbench for the conversion sequencer
`timescale 1ns/1ps
module test_adc_conversion_sequencer_timing;
   reg        clk = 1'b0, rst = 1'b1, soc = 1'b0, clr = 1'b0, ce = 1'b1;
   reg  [4:0] win = 5'h00;
   reg  [7:0] div = 8'h00;
   reg  [9:0] val = 10'h000;
   wire [9:0] data, result;
   wire       samp, conv, done, irq, busy;
   integer    n_fail = 0, checked = 0;
   initial forever #2.5 clk = ~clk;
   acs_sequencer i_dut (.sys_clk_in(clk), .rst_in(rst), .ce_in(ce),
      .soc_in(soc), .acquisition_window_prescale_in(win),
      .conv_clk_div_in(div), .flag_clear_in(clr), .conv_data_in(data),
      .sample_out(samp), .convert_out(conv), .result_out(result),
      .done_flag_out(done), .irq_out(irq), .busy_out(busy));
   acs_analog_model i_ana (.sys_clk_in(clk), .sample_in(samp),
      .convert_in(conv), .busy_in(busy), .value_in(val), .data_out(data));
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", checked, n_fail);
         if (n_fail == 0 && checked > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   task run(input [4:0] w, input [7:0] d, input [9:0] v);
      integer i, ns, ni, t, dd, nc;
      begin
         t = (w < 1) ? 2 : w + 1;
         dd = (d < 7) ? 7 : d;
         @(negedge clk); win = w; div = d; val = v; soc = 1'b1;
         @(negedge clk); soc = 1'b0; ns = 0; ni = 0; nc = 0;
         chk(busy, 1);
         for (i = 0; i < 20000 && busy; i = i + 1) begin
            @(negedge clk);
            // Trigger while busy must be ignored
            soc = (i == 20);
            ns = ns + samp;
            nc = nc + conv;
         end
         if (busy) begin
            n_fail = n_fail + 1;
            complete_run;
         end
         chk(i >= 100, 1);
         // First tick lands one cycle late, behind the tick register
         chk(ns >= t * dd && ns <= t * dd + 1, 1);
         chk(nc, 10 * dd);
         chk(result, v);
         for (ns = 0; ns < 3; ns = ns + 1) begin
            @(negedge clk); ni = ni + irq;
         end
         chk(ni, 1);
         chk(done, 1);
         chk(busy, 0);
         clr = 1'b1;
         @(negedge clk); clr = 1'b0;
         chk(done, 0);
         $display("run w=%0d d=%0d ended", w, d);
      end
   endtask
   task frozen;
      begin
         @(negedge clk); ce = 1'b0; soc = 1'b1;
         @(negedge clk); soc = 1'b0;
         chk(busy, 0);
         ce = 1'b1;
         @(negedge clk);
         chk(busy, 0);
         $display("frozen trigger ended");
      end
   endtask
   initial begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      run(5'h00, 8'h00, 10'h2A5);
      run(5'h1F, 8'h09, 10'h15A);
      run(5'h06, 8'h07, 10'h3FF);
      frozen;
      complete_run;
   end
endmodule // test_adc_conversion_sequencer_timing
